// ==== acs_pkg.sv ====
package acs_pkg;
   // Word layout and register sizes.
   localparam int          WORD_W          = 32;
   localparam int          NUM_CH          = 4;
   localparam int          NUM_SETUP       = 8;
   localparam int          OFS_ZERO_BITS   = 8;
   localparam logic [31:0] OFS_RESET       = 32'h00000000;
   localparam logic [31:0] GAIN_RESET      = 32'h01000000;
   localparam logic [31:0] OFS_LOW_MASK    = 32'hffffff00;
   localparam logic [29:0] GAIN_UNITY      = 30'h01000000;
   localparam int          GAIN_FRAC_BITS  = 24;
   // Offset step scale 1.835007966 as Q2.30 fixed point.
   localparam logic [31:0] OFS_SCALE_Q30   = 32'h7570c540;

   // Command byte layout.
   localparam int          CMD_CAL_BIT     = 7;
   localparam int          CMD_PTR_LSB     = 3;
   localparam int          CMD_TYPE_LSB    = 0;

   // Calibration type field values.
   localparam logic [2:0]  CAL_SELF_OFS    = 3'h1;
   localparam logic [2:0]  CAL_SELF_GAIN   = 3'h2;
   localparam logic [2:0]  CAL_SYS_OFS     = 3'h5;
   localparam logic [2:0]  CAL_SYS_GAIN    = 3'h6;

   // Timing: cycles a calibration ends before a single conversion.
   localparam logic [11:0] OFS_EARLY_FRS0  = 12'd608;
   localparam logic [11:0] OFS_EARLY_FRS1  = 12'd729;
   localparam logic [11:0] GAIN_EARLY_FRS0 = 12'd128;
   localparam logic [11:0] GAIN_EARLY_FRS1 = 12'd153;

   // Serial frame lengths in link clocks.
   localparam int          CMD_BITS        = 8;
   localparam int          DATA_BITS       = 32;

   // Host port register map.
   localparam logic [3:0]  HR_CTRL         = 4'h0;
   localparam logic [3:0]  HR_WDATA        = 4'h1;
   localparam logic [3:0]  HR_RDATA        = 4'h2;
   localparam logic [3:0]  HR_STATUS       = 4'h3;
   localparam int          HOST_DIV        = 8;

   // Single-conversion length in master clocks for a rate code.
   function automatic logic [21:0] acs_conv_cycles(input logic [3:0] wr, input logic rate_scale_bit);
      logic [21:0] c;
      c = 22'd0;
      unique case (wr)
         4'h0: c = rate_scale_bit ? 22'd205738 : 22'd171448;
         4'h1: c = rate_scale_bit ? 22'd402346 : 22'd335288;
         4'h2: c = rate_scale_bit ? 22'd795562 : 22'd662968;
         4'h3: c = rate_scale_bit ? 22'd1581994 : 22'd1318328;
         4'h4: c = rate_scale_bit ? 22'd3154858 : 22'd2629048;
         4'h8: c = rate_scale_bit ? 22'd9110 : 22'd7592;
         4'h9: c = rate_scale_bit ? 22'd21418 : 22'd17848;
         4'ha: c = rate_scale_bit ? 22'd33706 : 22'd28088;
         4'hb: c = rate_scale_bit ? 22'd58282 : 22'd48568;
         default: c = rate_scale_bit ? 22'd107434 : 22'd89528;
      endcase
      return c;
   endfunction : acs_conv_cycles
endpackage : acs_pkg

// ==== acs_link_if.sv ====
`timescale 1ns/1ps
`default_nettype none
interface acs_link_if;
   logic sclk;
   logic sdi;
   logic serial_data_output;
   modport dev  (input sclk, input sdi, output serial_data_output);
   modport host (output sclk, output sdi, input serial_data_output);
endinterface : acs_link_if
`default_nettype wire

// ==== acs_cal_dev.sv ====
// How it works
// [RULE_01] Offset trims are 32 bits, low byte zero.
// [RULE_02] Trim aligns to data word at MSB.
// [RULE_03] Reset clears every offset trim.
// [RULE_04] Offset LSB is 1.835007966 times 2^-24.
// [RULE_05] Calibration command: top bit, pointer, type.
// [RULE_06] Calibration uses the pointed setup register.
// [RULE_07] Offset cal ends 608/729 cycles early.
// [RULE_08] Gain cal ends 128/153 cycles early.
// [RULE_09] Override off: store to own channel, SERIAL_DATA_OUTPUT low.
// [RULE_10] Override on: store to pointed register set.
// [RULE_11] SERIAL_DATA_OUTPUT stays low until next command.
// [RULE_12] One calibration per command, last wins.
// [RULE_13] Self offset shorts inputs, valid at 1x.
// [RULE_14] Host uses input short for higher gains.
// [RULE_15] Self gain uses reference at 1x.
// [RULE_16] System cal signals come from outside.
// [RULE_17] Cal runs at the setup's word rate.
// [RULE_18] Host picks fast or slow cal rates.
// [RULE_19] Host stays off port during calibration.
// [RULE_20] Host reads and restores cal registers.
// [RULE_21] Offset scaled and gain-multiplied for output.
// [RULE_22] Override off: one range per channel.
// [RULE_23] Pointer 00..11 selects channel 1..4.
// [RULE_24] Gain resets to unity, D24 set.
//
// Our own choices: strobed register access and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module acs_cal_dev
   import acs_pkg::*;
#(
   parameter int NCH = NUM_CH
)(
   // Clock and reset.
   input  wire logic        SYS_CLK,
   input  wire logic        NRST,
   // Serial link.
   acs_link_if.dev          LINK,
   // Analog front end and measurement.
   input  wire logic [31:0] MEAS_RESULT,
   input  wire logic [31:0] RAW_CONV,
   input  wire logic        CAL_REG_SELECT_OVERRIDE,
   input  wire logic        INPUT_SHORT,
   input  wire logic        RATE_SCALE_BIT,
   output logic [2:0]       FRONT_ROUTE,
   output logic [2:0]       GAIN_APPLIED,
   output logic             CAL_BUSY,
   output logic [31:0]      CORRECTED_CONV
);
   // Refuse a channel count that the register arrays cannot hold.
   if (NCH < 1 || NCH > NUM_CH) begin : g_nch_bad
      $error("NCH out of range");
   end

   // ************************************************************
   // Link synchronisers and edge detect.
   // ************************************************************
   logic [1:0] sclk_sync_reg;
   logic [1:0] sdi_sync_reg;
   logic       sclk_last_reg;
   logic       sclk_rise;
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         sclk_sync_reg <= 2'h0;
         sdi_sync_reg  <= 2'h0;
         sclk_last_reg <= 1'b0;
      end else begin
         sclk_sync_reg <= {sclk_sync_reg[0], LINK.sclk};
         sdi_sync_reg  <= {sdi_sync_reg[0], LINK.sdi};
         sclk_last_reg <= sclk_sync_reg[1];
      end
   end
   assign sclk_rise = sclk_sync_reg[1] & ~sclk_last_reg;

   // ************************************************************
   // Registers and sequencer state.
   // ************************************************************
   typedef enum logic [4:0] {
      ST_CMD  = 5'b00001,
      ST_ARG  = 5'b00010,
      ST_RD   = 5'b00100,
      ST_CAL  = 5'b01000,
      ST_DONE = 5'b10000
   } acs_dev_st_t;

   acs_dev_st_t  st_reg;
   logic [7:0]   cmd_reg;
   logic [31:0]  shift_reg;
   logic [5:0]   bit_cnt_reg;
   logic [21:0]  cal_cnt_reg;
   logic         sdo_reg;
   logic [31:0]  ofs_reg   [NUM_CH];
   logic [31:0]  gain_reg  [NUM_CH];
   logic [31:0]  setup_reg [NUM_SETUP];
   logic [1:0]   tgt_reg;
   logic [31:0]  corr_reg;

   // Command byte: bit7 cal; on a cal bits5..3 pointer and bits2..0 type.
   // Otherwise bit5 read, bits1..0 0 offset, 1 gain, 2 setup; index bits4..3, setup index bits4..2.
   logic [7:0]   cmd_now;
   logic [2:0]   cmd_ptr;
   logic [2:0]   cmd_type;
   logic [31:0]  sel_setup;
   logic [1:0]   sel_ch;
   logic         is_ofs_cal;
   logic [11:0]  early;
   assign cmd_ptr  = cmd_reg[CMD_PTR_LSB +: 3];
   assign cmd_type = cmd_reg[CMD_TYPE_LSB +: 3];
   // Whole command byte as it stands at its eighth link clock.
   assign cmd_now  = {shift_reg[6:0], sdi_sync_reg[1]};
   // [RULE_06] Pointed setup fields.
   assign sel_setup  = setup_reg[cmd_ptr];
   assign sel_ch     = sel_setup[31:30];
   assign is_ofs_cal = (cmd_type == CAL_SELF_OFS) || (cmd_type == CAL_SYS_OFS);
   // [RULE_07] [RULE_08] Early finish margin.
   assign early = is_ofs_cal ? (RATE_SCALE_BIT ? OFS_EARLY_FRS1 : OFS_EARLY_FRS0)
                             : (RATE_SCALE_BIT ? GAIN_EARLY_FRS1 : GAIN_EARLY_FRS0);

   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         st_reg      <= ST_CMD;
         cmd_reg     <= 8'h00;
         shift_reg   <= 32'h00000000;
         bit_cnt_reg <= 6'h00;
         cal_cnt_reg <= 22'h000000;
         sdo_reg     <= 1'b1;
         tgt_reg     <= 2'h0;
         for (int i = 0; i < NUM_CH; i++) begin
            // [RULE_03] [RULE_24] Reset trims.
            ofs_reg[i]  <= OFS_RESET;
            gain_reg[i] <= GAIN_RESET;
         end
         for (int i = 0; i < NUM_SETUP; i++) setup_reg[i] <= 32'h00000000;
      end else begin
         unique case (st_reg)
            ST_CMD: if (sclk_rise) begin
               // [RULE_11] Next command word releases SERIAL_DATA_OUTPUT.
               sdo_reg   <= 1'b1;
               shift_reg <= {shift_reg[30:0], sdi_sync_reg[1]};
               if (bit_cnt_reg == 6'(CMD_BITS - 1)) begin
                  bit_cnt_reg <= 6'h00;
                  cmd_reg     <= cmd_now;
                  // [RULE_05] Top bit starts calibration.
                  if (cmd_now[CMD_CAL_BIT]) begin
                     st_reg      <= ST_CAL;
                     cal_cnt_reg <= 22'h000000;
                     // [RULE_09] [RULE_22] Own channel's register set.
                     tgt_reg     <= setup_reg[cmd_now[CMD_PTR_LSB +: 3]][31:30];
                     // [RULE_10] [RULE_23] Override picks pointed set.
                     if (CAL_REG_SELECT_OVERRIDE)
                        tgt_reg <= setup_reg[cmd_now[CMD_PTR_LSB +: 3]][17:16];
                  end else if (cmd_now[5]) begin
                     st_reg    <= ST_RD;
                     shift_reg <= (cmd_now[1:0] == 2'h0) ? ofs_reg[cmd_now[4:3]] :
                                  (cmd_now[1:0] == 2'h1) ? gain_reg[cmd_now[4:3]] :
                                                           setup_reg[cmd_now[4:2]];
                  end else begin
                     st_reg <= ST_ARG;
                  end
               end else begin
                  bit_cnt_reg <= bit_cnt_reg + 6'h01;
               end
            end
            ST_ARG: if (sclk_rise) begin
               shift_reg <= {shift_reg[30:0], sdi_sync_reg[1]};
               if (bit_cnt_reg == 6'(DATA_BITS - 1)) begin
                  bit_cnt_reg <= 6'h00;
                  st_reg      <= ST_CMD;
                  // [RULE_20] Restore saved words.
                  unique case (cmd_reg[1:0])
                     2'h0: ofs_reg[cmd_reg[4:3]]  <= {shift_reg[30:0], sdi_sync_reg[1]} & OFS_LOW_MASK;
                     2'h1: gain_reg[cmd_reg[4:3]] <= {2'h0, shift_reg[28:0], sdi_sync_reg[1]};
                     default: setup_reg[cmd_reg[4:2]] <= {shift_reg[30:0], sdi_sync_reg[1]};
                  endcase
               end else begin
                  bit_cnt_reg <= bit_cnt_reg + 6'h01;
               end
            end
            ST_RD: if (sclk_rise) begin
               shift_reg <= {shift_reg[30:0], 1'b0};
               if (bit_cnt_reg == 6'(DATA_BITS - 1)) begin
                  bit_cnt_reg <= 6'h00;
                  st_reg      <= ST_CMD;
               end else begin
                  bit_cnt_reg <= bit_cnt_reg + 6'h01;
               end
            end
            ST_CAL: begin
               cal_cnt_reg <= cal_cnt_reg + 22'h000001;
               // [RULE_17] Length from the setup word rate.
               if (cal_cnt_reg + 22'(early) + 22'h000001 >= acs_conv_cycles(sel_setup[26:23], RATE_SCALE_BIT))
                  st_reg <= ST_DONE;
            end
            ST_DONE: begin
               // [RULE_09] [RULE_12] Store one result, signal.
               if (is_ofs_cal)
                  // [RULE_01] [RULE_02] MSB-aligned, low byte zero.
                  ofs_reg[tgt_reg] <= MEAS_RESULT & OFS_LOW_MASK;
               else
                  gain_reg[tgt_reg] <= {2'h0, MEAS_RESULT[29:0]};
               sdo_reg <= 1'b0;
               st_reg  <= ST_CMD;
            end
            default: st_reg <= ST_CMD;
         endcase
      end
   end

   // ************************************************************
   // Front-end routing and output correction.
   // ************************************************************
   // [RULE_13] [RULE_15] Self cal routing and 1x gain.
   always_comb begin
      FRONT_ROUTE  = 3'h0;
      GAIN_APPLIED = sel_setup[29:27];
      if (st_reg == ST_CAL) begin
         if (cmd_type == CAL_SELF_OFS) begin
            FRONT_ROUTE  = 3'h1;
            GAIN_APPLIED = 3'h0;
         end else if (cmd_type == CAL_SELF_GAIN) begin
            FRONT_ROUTE  = 3'h2;
            GAIN_APPLIED = 3'h0;
         end else if (cmd_type == CAL_SYS_OFS && INPUT_SHORT) begin
            // [RULE_14] Input short for system offset.
            FRONT_ROUTE = 3'h3;
         end
      end
   end

   // [RULE_04] [RULE_21] Scaled offset times gain.
   logic signed [63:0] ofs_scaled;
   logic signed [63:0] ofs_gained;
   logic signed [63:0] gain_term;
   assign ofs_scaled = (64'(signed'(ofs_reg[sel_ch])) * 64'(signed'({1'b0, OFS_SCALE_Q30}))) >>> 30;
   assign ofs_gained = (ofs_scaled * 64'(signed'({1'b0, gain_reg[sel_ch]}))) >>> GAIN_FRAC_BITS;
   assign gain_term  = (64'(signed'(RAW_CONV)) * 64'(signed'({1'b0, gain_reg[sel_ch]}))) >>> GAIN_FRAC_BITS;
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) corr_reg <= 32'h00000000;
      else       corr_reg <= 32'(gain_term - ofs_gained);
   end

   assign LINK.serial_data_output       = (st_reg == ST_RD) ? shift_reg[31] : sdo_reg;
   assign CAL_BUSY       = (st_reg == ST_CAL) || (st_reg == ST_DONE);
   assign CORRECTED_CONV = corr_reg;
endmodule : acs_cal_dev
`default_nettype wire

// ==== acs_cal_host.sv ====
`timescale 1ns/1ps
`default_nettype none
module acs_cal_host
   import acs_pkg::*;
(
   // Clock and reset.
   input  wire logic        SYS_CLK,
   input  wire logic        NRST,
   // Register port.
   input  wire logic [3:0]  ADDR,
   input  wire logic [31:0] WDATA,
   input  wire logic        WR,
   input  wire logic        RD,
   output logic [31:0]      RDATA,
   // Serial link.
   acs_link_if.host         LINK
);
   typedef enum logic [2:0] {
      HS_IDLE = 3'b001,
      HS_SEND = 3'b010,
      HS_WAIT = 3'b100
   } acs_host_st_t;

   acs_host_st_t st_reg;
   logic [39:0]  tx_reg;
   logic [31:0]  wdata_reg;
   logic [31:0]  rx_reg;
   logic [5:0]   bits_reg;
   logic [3:0]   div_reg;
   logic         sclk_reg;
   logic [1:0]   sdo_sync_reg;
   logic         cal_reg;
   logic [31:0]  rdata_reg;

   always_ff @(posedge SYS_CLK) begin
      if (!NRST) sdo_sync_reg <= 2'h3;
      else       sdo_sync_reg <= {sdo_sync_reg[0], LINK.serial_data_output};
   end

   // CTRL write: [7:0] command byte, [13:8] bit count to clock.
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         st_reg    <= HS_IDLE;
         tx_reg    <= 40'h0000000000;
         wdata_reg <= 32'h00000000;
         rx_reg    <= 32'h00000000;
         bits_reg  <= 6'h00;
         div_reg   <= 4'h0;
         sclk_reg  <= 1'b0;
         cal_reg   <= 1'b0;
      end else begin
         if (WR && ADDR == HR_WDATA) wdata_reg <= WDATA;
         unique case (st_reg)
            HS_IDLE: if (WR && ADDR == HR_CTRL) begin
               tx_reg   <= {WDATA[7:0], wdata_reg};
               bits_reg <= WDATA[13:8];
               // [RULE_05] Calibration command flag.
               cal_reg  <= WDATA[CMD_CAL_BIT];
               div_reg  <= 4'h0;
               st_reg   <= HS_SEND;
            end
            HS_SEND: begin
               div_reg <= div_reg + 4'h1;
               if (div_reg == 4'(HOST_DIV - 1)) begin
                  div_reg  <= 4'h0;
                  sclk_reg <= ~sclk_reg;
                  if (sclk_reg) begin
                     tx_reg   <= {tx_reg[38:0], 1'b0};
                     bits_reg <= bits_reg - 6'h01;
                     if (bits_reg == 6'h01)
                        st_reg <= cal_reg ? HS_WAIT : HS_IDLE;
                  end else begin
                     rx_reg <= {rx_reg[30:0], sdo_sync_reg[1]};
                  end
               end
            end
            // [RULE_19] Wait for completion.
            HS_WAIT: if (!sdo_sync_reg[1]) begin
               cal_reg <= 1'b0;
               st_reg  <= HS_IDLE;
            end
            default: st_reg <= HS_IDLE;
         endcase
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!NRST) rdata_reg <= 32'h00000000;
      else if (RD) begin
         unique case (ADDR)
            HR_WDATA:  rdata_reg <= wdata_reg;
            HR_RDATA:  rdata_reg <= rx_reg;
            HR_STATUS: rdata_reg <= {29'h0, ~sdo_sync_reg[1], cal_reg, st_reg != HS_IDLE};
            default:   rdata_reg <= 32'h00000000;
         endcase
      end
   end

   assign RDATA    = rdata_reg;
   assign LINK.sclk = sclk_reg;
   assign LINK.sdi  = (st_reg == HS_SEND) ? tx_reg[39] : 1'b0;
endmodule : acs_cal_host
`default_nettype wire

// ==== acs_cal_monitor.sv ====
`timescale 1ns/1ps
`default_nettype none
module acs_cal_monitor #(
   parameter int CAL_MIN = 6970,
   parameter int CAL_MAX = 8980
)(
   // Clock and reset.
   input wire logic SYS_CLK,
   input wire logic NRST,
   // Link signals.
   input wire logic sclk,
   input wire logic sdi,
   input wire logic serial_data_output
);
   logic        sclk_q;
   logic        sdo_q;
   logic        rise;
   logic [5:0]  bit_cnt;
   logic [7:0]  cmd_sr;
   logic        cal_pend;
   logic [3:0]  since_rise;
   logic [13:0] cal_cnt;

   assign rise = sclk && !sclk_q;

   always_ff @(posedge SYS_CLK) begin
      sclk_q <= NRST ? sclk : 1'b0;
      sdo_q  <= NRST ? serial_data_output : 1'b1;
   end

   // A calibration frame ends after its command byte, any other after 40 bits.
   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         bit_cnt <= 6'd0;
         cmd_sr  <= 8'h00;
      end else if (rise) begin
         cmd_sr  <= {cmd_sr[6:0], sdi};
         bit_cnt <= ((bit_cnt == 6'd7 && cmd_sr[6]) || bit_cnt == 6'd39) ? 6'd0 : bit_cnt + 6'd1;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         cal_pend <= 1'b0;
      end else if (rise && bit_cnt == 6'd7 && cmd_sr[6]) begin
         cal_pend <= 1'b1;
      end else if (sdo_q && !serial_data_output) begin
         cal_pend <= 1'b0;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      cal_cnt <= (!NRST || !cal_pend) ? 14'd0 : cal_cnt + 14'd1;
   end

   always_ff @(posedge SYS_CLK) begin
      if (!NRST) begin
         since_rise <= 4'hf;
      end else if (rise) begin
         since_rise <= 4'h0;
      end else if (since_rise != 4'hf) begin
         since_rise <= since_rise + 4'h1;
      end
   end

   default clocking cb @(posedge SYS_CLK); endclocking
   default disable iff (!NRST);

   reset_idle_a: assert property (disable iff (1'b0) $rose(NRST) |-> serial_data_output && !sclk)
      else $error("link not idle after reset");
   sdo_hold_a: assert property ($rose(serial_data_output) |-> since_rise <= 4'd10)
      else $error("sdo rose without link clock activity");
   cal_quiet_a: assert property (cal_pend |-> !rise)
      else $error("link clock pulsed during calibration");
   sdi_stable_a: assert property (sclk && $past(sclk) |-> $stable(sdi))
      else $error("sdi changed while link clock high");
   clock_high_a: assert property ($rose(sclk) |-> sclk [*8] ##1 !sclk)
      else $error("link clock high phase not 8 cycles");
   cal_early_a: assert property (cal_pend && cal_cnt < CAL_MIN |-> serial_data_output)
      else $error("calibration finished too soon");
   cal_late_a: assert property (cal_pend |-> cal_cnt <= CAL_MAX)
      else $error("calibration took too long");
   read_edge_a: assert property ($fell(serial_data_output) && !cal_pend |-> since_rise <= 4'd10)
      else $error("sdo fell outside a transfer");

   cover property (cal_pend && $fell(serial_data_output));
   cover property (rise && bit_cnt == 6'd39);
   cover property (rise && bit_cnt == 6'd7 && cmd_sr[6]);
endmodule : acs_cal_monitor
`default_nettype wire

// ==== tb_adc_calibration_sequencer.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb_adc_calibration_sequencer;
   import acs_pkg::*;
   logic        sys_clk = 1'b0;
   logic        nrst = 1'b0;
   logic [3:0]  addr = 4'h0;
   logic [31:0] wdata = 32'h0;
   logic        wr = 1'b0;
   logic        rd = 1'b0;
   logic [31:0] rdata;
   logic [31:0] meas = 32'h0;
   logic [31:0] raw = 32'h0;
   logic        ovr = 1'b0;
   logic        ishort = 1'b0;
   logic        rate_scale_bit = 1'b0;
   logic [2:0]  route;
   logic [2:0]  gapp;
   logic        busy;
   logic [31:0] corr;
   logic [31:0] lfsr = 32'h0000004c;
   logic [31:0] d;
   logic [2:0]  rs;
   logic [2:0]  gs;
   int          bcnt = 0;
   int          n_errors = 0;
   int          checks_done = 0;
   int          ofs_m[4];
   int          gain_m[4];

   acs_link_if link ();
   acs_cal_host u_acs_cal_host (.SYS_CLK(sys_clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
      .RDATA(rdata), .LINK(link));
   acs_cal_dev u_acs_cal_dev (.SYS_CLK(sys_clk), .NRST(nrst), .LINK(link), .MEAS_RESULT(meas), .RAW_CONV(raw),
      .CAL_REG_SELECT_OVERRIDE(ovr), .INPUT_SHORT(ishort), .RATE_SCALE_BIT(rate_scale_bit), .FRONT_ROUTE(route),
      .GAIN_APPLIED(gapp), .CAL_BUSY(busy), .CORRECTED_CONV(corr));
   acs_cal_monitor u_acs_cal_monitor (.SYS_CLK(sys_clk), .NRST(nrst), .sclk(link.sclk), .sdi(link.sdi),
      .serial_data_output(link.serial_data_output));

   always #5 sys_clk = ~sys_clk;

   // Records the calibration length and the front-end state in its first cycle.
   always @(posedge sys_clk) begin
      if (busy === 1'b1) begin
         if (bcnt == 0) begin
            rs = route;
            gs = gapp;
         end
         bcnt++;
      end
   end

   function automatic logic [31:0] rnd(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : rnd

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         n_errors++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check

   task automatic results();
      $display("Errors %0d, checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : results

   task automatic hw(input logic [3:0] a, input logic [31:0] v);
      @(posedge sys_clk);
      addr <= a;
      wdata <= v;
      wr <= 1'b1;
      @(posedge sys_clk);
      wr <= 1'b0;
   endtask : hw

   task automatic hr(input logic [3:0] a);
      @(posedge sys_clk);
      addr <= a;
      rd <= 1'b1;
      @(posedge sys_clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask : hr

   // One link frame through the host port; a timeout ends the run.
   task automatic xfer(input logic [7:0] cmd, input logic [31:0] v);
      int i;
      hw(HR_WDATA, v);
      hw(HR_CTRL, {18'h0, cmd[7] ? 6'd8 : 6'd40, cmd});
      for (i = 0; i < 20000; i++) begin
         hr(HR_STATUS);
         if (d[1:0] === 2'b00) break;
      end
      if (i == 20000) begin
         n_errors++;
         results();
      end
      hr(HR_RDATA);
   endtask : xfer

   initial begin
      int k, t, tgt, len;
      logic [2:0] ty;
      logic [2:0] tys[4];
      logic [31:0] em;
      tys = '{CAL_SELF_OFS, CAL_SELF_GAIN, CAL_SYS_OFS, CAL_SYS_GAIN};
      repeat (3) @(posedge sys_clk);
      nrst <= 1'b1;
      raw <= lfsr;
      repeat (2) @(posedge sys_clk);
      #1 check(corr, lfsr);
      for (k = 0; k < 4; k++) begin
         ofs_m[k] = 0;
         gain_m[k] = GAIN_RESET;
         xfer(8'(32'h20 | (k << 3)), 32'h0);
         check(d, ofs_m[k]);
         xfer(8'(32'h21 | (k << 3)), 32'h0);
         check(d, gain_m[k]);
         lfsr = rnd(lfsr);
         ofs_m[k] = lfsr & OFS_LOW_MASK;
         xfer(8'(k << 3), lfsr);
         xfer(8'(32'h20 | (k << 3)), 32'h0);
         check(d, ofs_m[k]);
      end
      // Setup 7 is still clear, so channel 0 with unity gain corrects the output.
      check(corr, 32'(longint'(signed'(raw)) - ((longint'(ofs_m[0]) * longint'(OFS_SCALE_Q30)) >>> 30)));
      for (t = 0; t < 6; t++) begin
         lfsr = rnd(lfsr);
         ty = tys[t % 4];
         xfer(8'({lfsr[2:0], 2'h2}), {lfsr[4:3], lfsr[7:5], 4'h8, 5'h0, lfsr[9:8], 16'h0});
         ovr <= lfsr[10];
         rate_scale_bit <= lfsr[11];
         ishort <= lfsr[12];
         em = rnd(lfsr);
         if (ty[1]) em[31:30] = 2'b00;
         meas <= em;
         bcnt = 0;
         xfer({2'b10, lfsr[2:0], ty}, 32'h0);
         len = (lfsr[11] ? 9110 : 7592) - (ty[1] ? (lfsr[11] ? 153 : 128) : (lfsr[11] ? 729 : 608)) + 1;
         check((bcnt >= len - 1 && bcnt <= len + 1) ? len : bcnt, len);
         check(32'(rs), ty == CAL_SELF_OFS ? 1 : ty == CAL_SELF_GAIN ? 2 : (ty == CAL_SYS_OFS && lfsr[12]) ? 3 : 0);
         check(32'(gs), ty[2] ? 32'(lfsr[7:5]) : 32'h0);
         tgt = lfsr[10] ? lfsr[9:8] : lfsr[4:3];
         if (ty[1]) gain_m[tgt] = em;
         else ofs_m[tgt] = em & OFS_LOW_MASK;
         hr(HR_STATUS);
         check(32'(d[2]), 32'h1);
         xfer(8'(32'h20 | (tgt << 3) | ty[1]), 32'h0);
         check(d, ty[1] ? gain_m[tgt] : ofs_m[tgt]);
      end
      results();
   end
endmodule : tb_adc_calibration_sequencer
`default_nettype wire
